/* rtl/icsr_pkg.sv */
package icsr_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NSRC = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_NORMAL_VECTOR = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_FAST_VECTOR = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 12'h10c;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_CORE_STATUS = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_CMD = 12'h120;
  localparam logic [ADDR_W-1:0] OFF_DISABLE_CMD = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_CMD = 12'h128;
  localparam logic [ADDR_W-1:0] OFF_SET_CMD = 12'h12c;
  localparam logic [ADDR_W-1:0] OFF_END_OF_SERVICE = 12'h130;
  localparam logic [ADDR_W-1:0] OFF_SPURIOUS = 12'h134;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_CTRL = 12'h138;
  localparam logic [ADDR_W-1:0] OFF_FF_ENABLE = 12'h140;
  localparam logic [ADDR_W-1:0] OFF_FF_DISABLE = 12'h144;
  localparam logic [ADDR_W-1:0] OFF_FF_STATUS = 12'h148;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 12'h150;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR = 12'h154;
  localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 12'h158;

  // ==========================================================
  // field positions and reset values
  localparam int BIT_FAST_SRC = 0;
  localparam int BIT_FAST_LINE = 0;
  localparam int BIT_NORMAL_LINE = 1;
  localparam int BIT_PROTECT = 0;
  localparam int BIT_GLOBAL_MASK = 1;
  localparam int BIT_EVT_EOS = 0;
  localparam int BIT_EVT_SPURIOUS = 1;
  localparam int NEVT = 2;
  localparam logic [NSRC-1:0] FF_VALID_BITS = 32'hffff_fffe;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_DEBUG = 2'h0;
  localparam logic [1:0] INIT_CAPTURE = 2'h2;

  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } icsr_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } icsr_axi_rsp_t;

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] mask;
    logic [NSRC-1:0] ffs;
    logic [DATA_W-1:0] spu;
    logic [1:0] debug;
    logic fast_line;
    logic normal_line;
    logic eos;
    logic [NEVT-1:0] evt_stat;
    logic [NEVT-1:0] evt_en;
    logic [1:0] init_cnt;
    logic [NSRC-1:0] ext_s1;
    logic [NSRC-1:0] ext_s2;
  } icsr_state_t;

endpackage

/* rtl/icsr_regs.sv */
`timescale 1ns/10ps

// Contract
// - pending readback shows one bit per source, 1 while that source is pending.
// - mask readback shows one bit per source, 1 while enabled, same layout.
// - core status bit 0 shows fast line active, bit 1 normal line active.
// - enable command sets mask bits written as 1, others unchanged.
// - disable command clears mask bits written as 1, others unchanged.
// - clear command clears pending bits written as 1, zeros have no effect.
// - set command sets pending bits written as 1, zeros have no effect.
// - any write to end-of-service location signals end of service, data ignored.
// - hold 32-bit spurious address; return it on spurious normal or fast vector read.
// - debug control bit 0 is a read/write protect mode bit.
// - global mask bit 1 of debug control forces both core lines inactive.
// - fast forcing enable sets bits 1 to 31 written as 1; bit 0 unused.
// - fast forcing disable clears bits written as 1, zeros unchanged.
// - fast forcing status reads 1 per source where forcing is enabled.
// - normal vector readback returns spurious address when no interrupt is current.
// - internal sources reset not pending; external pending takes its input level once, three cycles after reset.
module icsr_regs #(
  parameter logic [31:0] EXT_SRC_MASK = 32'h0000_0001  // which sources come from pins
) (
  input wire logic clk_i,  // system clock, 200 MHz
  input wire logic rst_i,  // async reset, active high
  input wire icsr_pkg::icsr_axi_req_t axi_req_i,  // axi4-lite requests from master
  output icsr_pkg::icsr_axi_rsp_t axi_rsp_o,  // axi4-lite responses to master
  input wire logic [31:0] src_set_i,  // pulses from source-type logic, set pending
  input wire logic [31:0] src_ack_clr_i,  // pulses from vector logic, clear pending
  input wire logic [31:0] ext_level_i,  // raw external source levels (pins)
  input wire logic normal_req_i,  // arbitration wants the normal line
  input wire logic cur_valid_i,  // a normal interrupt is current
  input wire logic [31:0] cur_vector_i,  // vector of the current normal interrupt
  input wire logic [31:0] fast_vector_i,  // vector programmed for the fast source
  output logic [31:0] pending_o,  // pending bits to arbitration
  output logic [31:0] mask_o,  // enable bits to arbitration
  output logic [31:0] fast_forcing_o,  // fast forcing bits to arbitration
  output logic end_of_service_o,  // one-cycle end-of-service pulse
  output logic protect_mode_o,  // protect mode level
  output logic core_fast_request_line_n_o,  // fast request to core, active low
  output logic core_normal_request_line_n_o,  // normal request to core, active low
  output logic irq_o  // level interrupt from enabled event bits
);

  // ==========================================================
  // helpers

  // expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // register select on word address
  function automatic logic hit(input logic [icsr_pkg::ADDR_W-1:0] a, input logic [icsr_pkg::ADDR_W-1:0] off);
    return a[icsr_pkg::ADDR_W-1:2] == off[icsr_pkg::ADDR_W-1:2];
  endfunction

  // ==========================================================
  // state

  icsr_pkg::icsr_state_t st;
  icsr_pkg::icsr_state_t next_st;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_exec;
  logic [31:0] wd;
  logic [icsr_pkg::ADDR_W-1:0] wa;
  logic [31:0] set_cmd;
  logic [31:0] clr_cmd;
  logic fast_active;
  logic [icsr_pkg::NEVT-1:0] evt_set;
  logic [icsr_pkg::NEVT-1:0] evt_clr;
  logic [31:0] rd_word;
  logic rd_ok;

  // handshakes: one write and one read at most in flight
  assign aw_take = axi_req_i.awvalid && !st.aw_have && !st.bvalid;
  assign w_take = axi_req_i.wvalid && !st.w_have && !st.bvalid;
  assign ar_take = axi_req_i.arvalid && !st.rvalid;
  assign wr_exec = st.aw_have && st.w_have;
  assign wa = st.aw_addr;
  assign wd = st.w_data & strb_mask(st.w_strb);  // lanes without strobe act as zero

  // fast line: fast source itself, or any forced source that is pending and enabled
  assign fast_active = |(st.pending & st.mask & (st.ffs | 32'h0000_0001));

  // ==========================================================
  // read mux
  always_comb begin
    rd_word = icsr_pkg::RST_WORD;
    rd_ok = 1'b1;
    if (hit(axi_req_i.araddr, icsr_pkg::OFF_PENDING)) begin
      rd_word = st.pending;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_MASK)) begin
      rd_word = st.mask;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_CORE_STATUS)) begin
      rd_word[icsr_pkg::BIT_FAST_LINE] = st.fast_line;
      rd_word[icsr_pkg::BIT_NORMAL_LINE] = st.normal_line;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_NORMAL_VECTOR)) begin
      rd_word = cur_valid_i ? cur_vector_i : st.spu;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_FAST_VECTOR)) begin
      rd_word = fast_active ? fast_vector_i : st.spu;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_SPURIOUS)) begin
      rd_word = st.spu;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_DEBUG_CTRL)) begin
      rd_word[1:0] = st.debug;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_FF_STATUS)) begin
      rd_word = st.ffs;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_EVT_STATUS)) begin
      rd_word[icsr_pkg::NEVT-1:0] = st.evt_stat;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_EVT_ENABLE)) begin
      rd_word[icsr_pkg::NEVT-1:0] = st.evt_en;
    end else if (hit(axi_req_i.araddr, icsr_pkg::OFF_ENABLE_CMD) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_DISABLE_CMD) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_CLEAR_CMD) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_SET_CMD) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_END_OF_SERVICE) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_FF_ENABLE) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_FF_DISABLE) ||
                 hit(axi_req_i.araddr, icsr_pkg::OFF_EVT_CLEAR)) begin
      rd_word = icsr_pkg::RST_WORD;  // write-only words read as zero
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st = st;
    set_cmd = '0;
    clr_cmd = '0;
    evt_set = '0;
    evt_clr = '0;
    next_st.eos = 1'b0;

    // external level synchroniser; first stage feeds only the second
    next_st.ext_s1 = ext_level_i;
    next_st.ext_s2 = st.ext_s1;
    if (st.init_cnt != 2'h3) begin
      next_st.init_cnt = st.init_cnt + 2'h1;
    end

    // write address and data are taken independently
    if (aw_take) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = axi_req_i.awaddr;
    end
    if (w_take) begin
      next_st.w_have = 1'b1;
      next_st.w_data = axi_req_i.wdata;
      next_st.w_strb = axi_req_i.wstrb;
    end
    if (st.bvalid && axi_req_i.bready) begin
      next_st.bvalid = 1'b0;
    end

    // execute a write once both halves are held; all bits act in one cycle
    if (wr_exec) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = icsr_pkg::RESP_OKAY;
      if (hit(wa, icsr_pkg::OFF_ENABLE_CMD)) begin
        next_st.mask = st.mask | wd;
      end else if (hit(wa, icsr_pkg::OFF_DISABLE_CMD)) begin
        next_st.mask = st.mask & ~wd;
      end else if (hit(wa, icsr_pkg::OFF_CLEAR_CMD)) begin
        clr_cmd = wd;
      end else if (hit(wa, icsr_pkg::OFF_SET_CMD)) begin
        set_cmd = wd;
      end else if (hit(wa, icsr_pkg::OFF_END_OF_SERVICE)) begin
        next_st.eos = 1'b1;
        evt_set[icsr_pkg::BIT_EVT_EOS] = 1'b1;
      end else if (hit(wa, icsr_pkg::OFF_SPURIOUS)) begin
        next_st.spu = (st.spu & ~strb_mask(st.w_strb)) | wd;
      end else if (hit(wa, icsr_pkg::OFF_DEBUG_CTRL)) begin
        if (st.w_strb[0]) begin
          next_st.debug = st.w_data[1:0];
        end
      end else if (hit(wa, icsr_pkg::OFF_FF_ENABLE)) begin
        next_st.ffs = st.ffs | (wd & icsr_pkg::FF_VALID_BITS);
      end else if (hit(wa, icsr_pkg::OFF_FF_DISABLE)) begin
        next_st.ffs = st.ffs & ~(wd & icsr_pkg::FF_VALID_BITS);
      end else if (hit(wa, icsr_pkg::OFF_EVT_CLEAR)) begin
        evt_clr = wd[icsr_pkg::NEVT-1:0];
      end else if (hit(wa, icsr_pkg::OFF_EVT_ENABLE)) begin
        next_st.evt_en = wd[icsr_pkg::NEVT-1:0];
      end else if (hit(wa, icsr_pkg::OFF_PENDING) || hit(wa, icsr_pkg::OFF_MASK) ||
                   hit(wa, icsr_pkg::OFF_CORE_STATUS) || hit(wa, icsr_pkg::OFF_NORMAL_VECTOR) ||
                   hit(wa, icsr_pkg::OFF_FAST_VECTOR) || hit(wa, icsr_pkg::OFF_FF_STATUS) ||
                   hit(wa, icsr_pkg::OFF_EVT_STATUS)) begin
        next_st.bresp = icsr_pkg::RESP_OKAY;  // read-only words ignore writes
      end else begin
        next_st.bresp = icsr_pkg::RESP_SLVERR;
      end
    end

    // read: answer one cycle after the address is taken
    if (st.rvalid && axi_req_i.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? icsr_pkg::RESP_OKAY : icsr_pkg::RESP_SLVERR;
      // a vector read that finds nothing to serve counts as spurious
      if ((hit(axi_req_i.araddr, icsr_pkg::OFF_NORMAL_VECTOR) && !cur_valid_i) ||
          (hit(axi_req_i.araddr, icsr_pkg::OFF_FAST_VECTOR) && !fast_active)) begin
        evt_set[icsr_pkg::BIT_EVT_SPURIOUS] = 1'b1;
      end
    end

    // pending: a set arriving with a clear wins, so no event is lost
    next_st.pending = (st.pending & ~(clr_cmd | src_ack_clr_i)) | set_cmd | src_set_i;
    if (st.init_cnt == icsr_pkg::INIT_CAPTURE) begin
      next_st.pending = next_st.pending | (st.ext_s2 & EXT_SRC_MASK);
    end

    // sticky event bits, set beats clear
    next_st.evt_stat = (st.evt_stat & ~evt_clr) | evt_set;

    // core lines, registered so status and pins agree
    next_st.fast_line = fast_active && !st.debug[icsr_pkg::BIT_GLOBAL_MASK];
    next_st.normal_line = normal_req_i && !st.debug[icsr_pkg::BIT_GLOBAL_MASK];
  end

  // ==========================================================
  // state register; reset loads constants only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.spu <= icsr_pkg::RST_WORD;
      st.debug <= icsr_pkg::RST_DEBUG;
      st.pending <= icsr_pkg::RST_WORD;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign axi_rsp_o.awready = !st.aw_have && !st.bvalid;
  assign axi_rsp_o.wready = !st.w_have && !st.bvalid;
  assign axi_rsp_o.bvalid = st.bvalid;
  assign axi_rsp_o.bresp = st.bresp;
  assign axi_rsp_o.arready = !st.rvalid;
  assign axi_rsp_o.rvalid = st.rvalid;
  assign axi_rsp_o.rdata = st.rdata;
  assign axi_rsp_o.rresp = st.rresp;
  assign pending_o = st.pending;
  assign mask_o = st.mask;
  assign fast_forcing_o = st.ffs;
  assign end_of_service_o = st.eos;
  assign protect_mode_o = st.debug[icsr_pkg::BIT_PROTECT];
  assign core_fast_request_line_n_o = !st.fast_line;
  assign core_normal_request_line_n_o = !st.normal_line;
  assign irq_o = |(st.evt_stat & st.evt_en);

endmodule

/* verif/icsr_core_model.sv */
`timescale 1ns/10ps
// ==========
// processor core request inputs
module icsr_core_model (
  input wire logic clk_i,  // system clock
  input wire logic fast_n_i,  // fast request, active low
  input wire logic normal_n_i,  // normal request, active low
  output logic fast_o,  // fast request seen by core
  output logic normal_o  // normal request seen by core
);
  // the core samples its lines on the clock, so a glitch never reaches the bench
  always_ff @(posedge clk_i) begin
    fast_o <= !fast_n_i;
    normal_o <= !normal_n_i;
  end
endmodule

/* verif/icsr_regs_sva.sv */
`timescale 1ns/10ps
// ==========
// port checks of the register block
module icsr_regs_sva (
  input wire logic clk_i,  // system clock
  input wire logic rst_i,  // async reset
  input wire icsr_pkg::icsr_axi_req_t axi_req_i,  // bus requests
  input wire icsr_pkg::icsr_axi_rsp_t axi_rsp_o,  // bus responses
  input wire logic [31:0] src_set_i,  // set pulses
  input wire logic [31:0] src_ack_clr_i,  // clear pulses
  input wire logic normal_req_i,  // normal line wanted
  input wire logic [31:0] pending_o,  // pending bits
  input wire logic [31:0] mask_o,  // enable bits
  input wire logic [31:0] fast_forcing_o,  // forcing bits
  input wire logic end_of_service_o,  // end of service pulse
  input wire logic core_fast_request_line_n_o,  // fast line
  input wire logic core_normal_request_line_n_o  // normal line
);
  // fast cause as one signal, so the line can be traced back a single cycle
  logic fast_cause;
  assign fast_cause = |(pending_o & mask_o & (fast_forcing_o | 32'h0000_0001));
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a set pulse must win over any clear of the same cycle
  set_wins_a: assert property (src_set_i != 32'h0 |=> (pending_o & $past(src_set_i)) == $past(src_set_i))
    else $error("set pulse lost");
  ack_clear_a: assert property (src_ack_clr_i != 32'h0 && src_set_i == 32'h0 |=>
    (pending_o & $past(src_ack_clr_i)) == 32'h0)
    else $error("clear pulse ignored");
  ff_bit0_a: assert property (fast_forcing_o[0] == 1'b0)
    else $error("forcing bit 0 set");
  fast_cause_a: assert property (!core_fast_request_line_n_o |-> $past(fast_cause))
    else $error("fast line without cause");
  normal_cause_a: assert property (!core_normal_request_line_n_o |-> $past(normal_req_i))
    else $error("normal line without request");
  eos_pulse_a: assert property (end_of_service_o |=> !end_of_service_o)
    else $error("end of service pulse too long");
  // enables only move with a write completing, never on their own
  mask_write_a: assert property ($changed(mask_o) |-> $rose(axi_rsp_o.bvalid))
    else $error("mask changed outside a write");
  write_answer_a: assert property (axi_req_i.awvalid && axi_rsp_o.awready &&
    axi_req_i.wvalid && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
    else $error("write response late");
  read_answer_a: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read data late");
endmodule

bind icsr_regs icsr_regs_sva icsr_regs_sva_inst (.clk_i, .rst_i, .axi_req_i, .axi_rsp_o, .src_set_i,
  .src_ack_clr_i, .normal_req_i, .pending_o, .mask_o, .fast_forcing_o, .end_of_service_o,
  .core_fast_request_line_n_o, .core_normal_request_line_n_o);

/* verif/icsr_regs_tb.sv */
`timescale 1ns/10ps
// ==========
// bench top
module icsr_regs_tb;
  logic clk_i;
  logic rst_i;
  icsr_pkg::icsr_axi_req_t rq;
  icsr_pkg::icsr_axi_rsp_t rs;
  logic [31:0] set_p, clr_p, ext, cur_vec, fast_vec, pend, msk, ffo;
  logic nreq, cur_v, eos, protect_mode_bit, fn, nn, irq, fast_s, norm_s;
  int errors, check_count, cyc, eos_cnt;

  icsr_regs icsr_regs_inst (.clk_i, .rst_i, .axi_req_i(rq), .axi_rsp_o(rs), .src_set_i(set_p),
    .src_ack_clr_i(clr_p), .ext_level_i(ext), .normal_req_i(nreq), .cur_valid_i(cur_v),
    .cur_vector_i(cur_vec), .fast_vector_i(fast_vec), .pending_o(pend), .mask_o(msk),
    .fast_forcing_o(ffo), .end_of_service_o(eos), .protect_mode_o(protect_mode_bit),
    .core_fast_request_line_n_o(fn), .core_normal_request_line_n_o(nn), .irq_o(irq));
  icsr_core_model icsr_core_model_inst (.clk_i, .fast_n_i(fn), .normal_n_i(nn), .fast_o(fast_s),
    .normal_o(norm_s));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // cycle ceiling cuts a hang short; pulses are counted here so none is missed
  always @(posedge clk_i) begin
    cyc++;
    if (eos === 1'b1) eos_cnt++;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // address and data are offered together and each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while ((rq.awvalid && !rs.awready) || (rq.wvalid && !rs.wready));
    do @(posedge clk_i); while (rs.bvalid !== 1'b1);
    cmp({30'h0, rs.bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    do @(posedge clk_i); while (rs.arready !== 1'b1);
    rq.arvalid <= 1'b0;
    do @(posedge clk_i); while (rs.rvalid !== 1'b1);
    cmp(rs.rdata, ed);
    cmp({30'h0, rs.rresp}, 32'h0);
  endtask

  task automatic t_reset();
    rd(icsr_pkg::OFF_PENDING, 32'h1);
    rd(icsr_pkg::OFF_MASK, 32'h0);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h0);
    rd(icsr_pkg::OFF_SPURIOUS, 32'h0);
    rd(icsr_pkg::OFF_DEBUG_CTRL, 32'h0);
    rd(icsr_pkg::OFF_FF_STATUS, 32'h0);
  endtask

  task automatic t_pend();
    wr(icsr_pkg::OFF_CLEAR_CMD, 32'hffff_ffff, 2'h0);
    rd(icsr_pkg::OFF_PENDING, 32'h0);
    wr(icsr_pkg::OFF_SET_CMD, 32'h8000_f0f0, 2'h0);
    rd(icsr_pkg::OFF_PENDING, 32'h8000_f0f0);
    wr(icsr_pkg::OFF_CLEAR_CMD, 32'h8000_3030, 2'h0);
    rd(icsr_pkg::OFF_PENDING, 32'h0000_c0c0);
    set_p <= 32'h0000_0200;
    @(posedge clk_i);
    set_p <= 32'h0;
    rd(icsr_pkg::OFF_PENDING, 32'h0000_c2c0);
    clr_p <= 32'h0000_0200;
    @(posedge clk_i);
    clr_p <= 32'h0;
    wr(icsr_pkg::OFF_PENDING, 32'hffff_ffff, 2'h0);
    rd(icsr_pkg::OFF_PENDING, 32'h0000_c0c0);
    cmp(pend, 32'h0000_c0c0);
  endtask

  task automatic t_mask();
    wr(icsr_pkg::OFF_ENABLE_CMD, 32'h8000_0006, 2'h0);
    rd(icsr_pkg::OFF_MASK, 32'h8000_0006);
    wr(icsr_pkg::OFF_DISABLE_CMD, 32'h8000_0002, 2'h0);
    rd(icsr_pkg::OFF_MASK, 32'h0000_0004);
    wr(icsr_pkg::OFF_ENABLE_CMD, 32'h1, 2'h0);
    rd(icsr_pkg::OFF_MASK, 32'h0000_0005);
    cmp(msk, 32'h0000_0005);
    rd(icsr_pkg::OFF_ENABLE_CMD, 32'h0);
  endtask

  // global mask must drop both lines even with causes present
  task automatic t_lines();
    wr(icsr_pkg::OFF_SET_CMD, 32'h1, 2'h0);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h1);
    cmp({31'h0, fast_s}, 32'h1);
    nreq <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h3);
    wr(icsr_pkg::OFF_DEBUG_CTRL, 32'hffff_ffff, 2'h0);
    rd(icsr_pkg::OFF_DEBUG_CTRL, 32'h3);
    cmp({31'h0, protect_mode_bit}, 32'h1);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h0);
    cmp({30'h0, fast_s, norm_s}, 32'h0);
    wr(icsr_pkg::OFF_DEBUG_CTRL, 32'h0, 2'h0);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h3);
    nreq <= 1'b0;
  endtask

  task automatic t_ff();
    wr(icsr_pkg::OFF_DISABLE_CMD, 32'h1, 2'h0);
    wr(icsr_pkg::OFF_FF_ENABLE, 32'hffff_ffff, 2'h0);
    rd(icsr_pkg::OFF_FF_STATUS, 32'hffff_fffe);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h0);
    wr(icsr_pkg::OFF_SET_CMD, 32'h4, 2'h0);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h1);
    wr(icsr_pkg::OFF_FF_DISABLE, 32'h4, 2'h0);
    rd(icsr_pkg::OFF_FF_STATUS, 32'hffff_fffa);
    cmp(ffo, 32'hffff_fffa);
    rd(icsr_pkg::OFF_CORE_STATUS, 32'h0);
  endtask

  task automatic t_spu();
    wr(icsr_pkg::OFF_SPURIOUS, 32'h1234_5678, 2'h0);
    rd(icsr_pkg::OFF_SPURIOUS, 32'h1234_5678);
    rd(icsr_pkg::OFF_NORMAL_VECTOR, 32'h1234_5678);
    rd(icsr_pkg::OFF_FAST_VECTOR, 32'h1234_5678);
    cur_v <= 1'b1;
    rd(icsr_pkg::OFF_NORMAL_VECTOR, 32'h0000_0abc);
    wr(icsr_pkg::OFF_ENABLE_CMD, 32'h1, 2'h0);
    rd(icsr_pkg::OFF_FAST_VECTOR, 32'h0000_0def);
    wr(icsr_pkg::OFF_DISABLE_CMD, 32'h1, 2'h0);
    cur_v <= 1'b0;
  endtask

  // event interrupt: raise, mask, clear, then a refused address
  task automatic t_evt();
    int n;
    wr(icsr_pkg::OFF_EVT_ENABLE, 32'h0, 2'h0);
    wr(icsr_pkg::OFF_EVT_CLEAR, 32'h3, 2'h0);
    rd(icsr_pkg::OFF_EVT_STATUS, 32'h0);
    n = eos_cnt;
    wr(icsr_pkg::OFF_END_OF_SERVICE, 32'hdead_beef, 2'h0);
    repeat (2) @(posedge clk_i);
    cmp(32'(eos_cnt - n), 32'h1);
    rd(icsr_pkg::OFF_EVT_STATUS, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(icsr_pkg::OFF_EVT_ENABLE, 32'h1, 2'h0);
    rd(icsr_pkg::OFF_EVT_ENABLE, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    wr(icsr_pkg::OFF_EVT_CLEAR, 32'h1, 2'h0);
    rd(icsr_pkg::OFF_EVT_STATUS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr(12'h1fc, 32'h1, 2'h2);
  endtask

  // second reset with the pin low: the captured pending bit must follow the pin
  task automatic t_rst2();
    ext <= 32'h0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(icsr_pkg::OFF_PENDING, 32'h0);
    rd(icsr_pkg::OFF_MASK, 32'h0);
    cmp({30'h0, fn, nn}, 32'h3);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // every input gets a value at time zero; the external pin stays high through reset
  initial begin
    rst_i = 1'b1;
    rq = '0;
    rq.bready = 1'b1;
    rq.rready = 1'b1;
    rq.wstrb = 4'hf;
    set_p = 32'h0;
    clr_p = 32'h0;
    ext = 32'h1;
    nreq = 1'b0;
    cur_v = 1'b0;
    cur_vec = 32'h0000_0abc;
    fast_vec = 32'h0000_0def;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    t_reset();
    t_pend();
    t_mask();
    t_lines();
    t_ff();
    t_spu();
    t_evt();
    t_rst2();
    finish_test();
  end
endmodule
